/* File: include/link_test_map.vh */
// Register map, field positions, reset values and counts of the receive link test logic.
`ifndef LINK_TEST_MAP_VH
`define LINK_TEST_MAP_VH

`define ADDR_W 12
`define OFS_TRANSPORT_TEST_CONTROL 12'h32c
`define OFS_EXPECTED_SAMPLE_LOW 12'h32d
`define OFS_EXPECTED_SAMPLE_HIGH 12'h32e
`define OFS_TRANSPORT_TEST_RESULT 12'h32f
`define OFS_COMMA_SYNC_LANE_STATUS 12'h470
`define OFS_LANE_ALIGN_SYNC_STATUS 12'h473
`define OFS_LINK_TEST_MODE 12'h477

`define CTRL_ENABLE_BIT 0
`define CTRL_RESET_BIT 1
`define CTRL_SELECT_LSB 4
`define CTRL_SELECT_MSB 7
`define RESULT_FAIL_BIT 0
`define TEST_MODE_ALIGN_BIT 7

`define RST_TRANSPORT_TEST_CONTROL 8'h00
`define RST_EXPECTED_SAMPLE_LOW 8'h00
`define RST_EXPECTED_SAMPLE_HIGH 8'h00
`define RST_LINK_TEST_MODE 8'h00

`define LANE_COUNT 8
`define SAMPLE_W 16
`define COMMA_COUNT_W 3
`define COMMAS_FOR_SYNC 3'h4
`define LANES_SIX 4'h6
`define LANES_THREE 4'h3
`define LANES_EIGHT 4'h8

`endif

/* File: src/lane_sync_monitor.v */
// Per lane comma sync and initial lane alignment pass tracking.
`timescale 1ns/100ps
`default_nettype none
`include "link_test_map.vh"

module lane_sync_monitor (
	input wire mclk_in,
	input wire srst_in,
	input wire lane_active_in,
	input wire char_valid_in,
	input wire comma_in,
	input wire sync_released_in,
	input wire align_done_in,
	output wire cgs_pass_out,
	output wire align_pass_out
);

	reg [`COMMA_COUNT_W-1:0] comma_count_ff;
	reg cgs_pass_ff;
	reg align_pass_ff;

	// A non-comma before the run completes restarts the count, so only consecutive commas qualify.
	always @(posedge mclk_in) begin
		if (srst_in || !lane_active_in) begin
			comma_count_ff <= {`COMMA_COUNT_W{1'b0}};
			cgs_pass_ff <= 1'b0;
		end else if (char_valid_in && !cgs_pass_ff) begin
			if (comma_in) begin
				comma_count_ff <= comma_count_ff + 3'h1;
				if (comma_count_ff == `COMMAS_FOR_SYNC - 3'h1) begin
					cgs_pass_ff <= 1'b1;
				end
			end else begin
				comma_count_ff <= {`COMMA_COUNT_W{1'b0}};
			end
		end
	end

	// Alignment pass counts only once the sync request has been released for this link.
	always @(posedge mclk_in) begin
		if (srst_in || !lane_active_in || !sync_released_in) begin
			align_pass_ff <= 1'b0;
		end else if (align_done_in) begin
			align_pass_ff <= 1'b1;
		end
	end

	assign cgs_pass_out = cgs_pass_ff;
	assign align_pass_out = align_pass_ff;

endmodule
`default_nettype wire

/* File: src/serial_link_rx_transport_test.v */
// Receive side link test logic: transport sample check and repeated sync and alignment tests.
`timescale 1ns/100ps
`default_nettype none
`include "link_test_map.vh"

module serial_link_rx_transport_test (
	input wire mclk_in,
	input wire srst_in,
	input wire [`ADDR_W-1:0] reg_addr_in,
	input wire reg_wr_in,
	input wire reg_rd_in,
	input wire [7:0] reg_wdata_in,
	output wire [7:0] reg_rdata_out,
	input wire [3:0] lane_count_in,
	input wire interp_bypass_in,
	input wire link_enable_in,
	input wire frame_valid_in,
	input wire [63:0] conv0_samples_in,
	input wire [31:0] conv1_samples_in,
	input wire [`LANE_COUNT-1:0] char_valid_in,
	input wire [`LANE_COUNT-1:0] comma_in,
	input wire [`LANE_COUNT-1:0] align_done_in,
	output wire sync_request_n_out,
	output wire transport_check_fail_out,
	output wire align_test_mode_out,
	output wire [`LANE_COUNT-1:0] cgs_pass_out,
	output wire [`LANE_COUNT-1:0] align_pass_out
);

	// Link mapping classes, one-hot.
	localparam [3:0] MODE_ONE_CONV_L8 = 4'b0001;
	localparam [3:0] MODE_TWO_CONV_L8 = 4'b0010;
	localparam [3:0] MODE_ONE_SAMPLE = 4'b0100;
	localparam [3:0] MODE_THREE_SAMPLE = 4'b1000;

	// Software visible storage.
	reg [7:0] transport_test_control_ff;
	reg [7:0] expected_sample_low_ff;
	reg [7:0] expected_sample_high_ff;
	reg [7:0] link_test_mode_ff;
	reg [7:0] rdata_ff;

	// Transport check pipeline.
	reg [`SAMPLE_W-1:0] picked_sample_ff;
	reg compare_valid_ff;
	reg force_fail_ff;
	reg transport_check_fail_flag_ff;

	// Sync request, registered so the pin never glitches.
	reg sync_request_n_ff;

	reg [7:0] nxt_rdata;
	reg nxt_fail;
	reg [3:0] link_mode;
	reg [`SAMPLE_W-1:0] selected_sample;

	wire transport_check_enable;
	wire transport_check_reset;
	wire [3:0] pattern_word_select;
	wire [`SAMPLE_W-1:0] expected_sample;
	wire [`LANE_COUNT-1:0] lane_active;
	wire [`LANE_COUNT-1:0] cgs_pass;
	wire [`LANE_COUNT-1:0] align_pass;
	wire all_lanes_synced;
	wire check_armed;

	// Classify the link from lane count and whether interpolation is bypassed.
	function [3:0] decode_mode;
		input bypass;
		input [3:0] lanes;
		begin
			if (lanes == `LANES_SIX || lanes == `LANES_THREE) begin
				decode_mode = MODE_THREE_SAMPLE;
			end else if (bypass) begin
				decode_mode = MODE_ONE_CONV_L8;
			end else if (lanes == `LANES_EIGHT) begin
				decode_mode = MODE_TWO_CONV_L8;
			end else begin
				decode_mode = MODE_ONE_SAMPLE;
			end
		end
	endfunction

	// Map a sample pattern word number onto the deframed converter sample it carries.
	function [`SAMPLE_W-1:0] pick_sample;
		input [3:0] mode;
		input [3:0] word;
		input [63:0] c0;
		input [31:0] c1;
		begin
			pick_sample = 16'h0000;
			case (mode)
				MODE_ONE_CONV_L8: begin
					// Samples 1 and 2 are swapped on this mapping.
					case (word[1:0])
						2'h0: pick_sample = c0[15:0];
						2'h1: pick_sample = c0[47:32];
						2'h2: pick_sample = c0[31:16];
						default: pick_sample = c0[63:48];
					endcase
				end
				MODE_TWO_CONV_L8: begin
					case (word[1:0])
						2'h0: pick_sample = c0[15:0];
						2'h1: pick_sample = c1[15:0];
						2'h2: pick_sample = c0[31:16];
						default: pick_sample = c1[31:16];
					endcase
				end
				MODE_ONE_SAMPLE: begin
					if (word[0]) begin
						pick_sample = c1[15:0];
					end else begin
						pick_sample = c0[15:0];
					end
				end
				default: begin
					pick_sample = 16'h0000;
				end
			endcase
		end
	endfunction

	// Enable mask for the lowest lanes of the configured lane count.
	function [`LANE_COUNT-1:0] lanes_in_use;
		input [3:0] lanes;
		integer i;
		begin
			lanes_in_use = {`LANE_COUNT{1'b0}};
			for (i = 0; i < `LANE_COUNT; i = i + 1) begin
				if (i < lanes) begin
					lanes_in_use[i] = 1'b1;
				end
			end
		end
	endfunction

	assign transport_check_enable = transport_test_control_ff[`CTRL_ENABLE_BIT];
	assign transport_check_reset = transport_test_control_ff[`CTRL_RESET_BIT];
	assign pattern_word_select = transport_test_control_ff[`CTRL_SELECT_MSB:`CTRL_SELECT_LSB];
	assign expected_sample = {expected_sample_high_ff, expected_sample_low_ff};

	// Comparison runs only while enabled and outside the test reset pulse.
	assign check_armed = transport_check_enable && !transport_check_reset;

	always @* begin
		link_mode = decode_mode(interp_bypass_in, lane_count_in);
		selected_sample = pick_sample(link_mode, pattern_word_select, conv0_samples_in, conv1_samples_in);
	end

	// Register writes; only the documented read write registers accept data.
	always @(posedge mclk_in) begin
		if (srst_in) begin
			transport_test_control_ff <= `RST_TRANSPORT_TEST_CONTROL;
			expected_sample_low_ff <= `RST_EXPECTED_SAMPLE_LOW;
			expected_sample_high_ff <= `RST_EXPECTED_SAMPLE_HIGH;
			link_test_mode_ff <= `RST_LINK_TEST_MODE;
		end else if (reg_wr_in) begin
			case (reg_addr_in)
				`OFS_TRANSPORT_TEST_CONTROL: begin
					transport_test_control_ff <= reg_wdata_in;
				end
				`OFS_EXPECTED_SAMPLE_LOW: begin
					expected_sample_low_ff <= reg_wdata_in;
				end
				`OFS_EXPECTED_SAMPLE_HIGH: begin
					expected_sample_high_ff <= reg_wdata_in;
				end
				`OFS_LINK_TEST_MODE: begin
					link_test_mode_ff <= reg_wdata_in;
				end
				default: begin
					transport_test_control_ff <= transport_test_control_ff;
				end
			endcase
		end
	end

	// Stage one: capture the selected word of each frame. Breaking the path here keeps the
	// four way select and the comparator out of the same clock period.
	always @(posedge mclk_in) begin
		if (srst_in) begin
			picked_sample_ff <= 16'h0000;
			compare_valid_ff <= 1'b0;
			force_fail_ff <= 1'b0;
		end else begin
			picked_sample_ff <= selected_sample;
			compare_valid_ff <= frame_valid_in && check_armed;
			force_fail_ff <= (link_mode == MODE_THREE_SAMPLE);
		end
	end

	// Stage two: sticky fail flag. A set and a clear cannot meet, because the comparison is
	// held off for as long as the test reset bit is high.
	always @* begin
		nxt_fail = transport_check_fail_flag_ff;
		if (transport_check_reset) begin
			nxt_fail = 1'b0;
		end
		if (compare_valid_ff && check_armed) begin
			if (force_fail_ff || picked_sample_ff != expected_sample) begin
				nxt_fail = 1'b1;
			end
		end
	end

	always @(posedge mclk_in) begin
		if (srst_in) begin
			transport_check_fail_flag_ff <= 1'b0;
		end else begin
			transport_check_fail_flag_ff <= nxt_fail;
		end
	end

	// Lane tracking for the repeated comma and alignment tests.
	assign lane_active = link_enable_in ? lanes_in_use(lane_count_in) : {`LANE_COUNT{1'b0}};

	genvar g;
	generate
		for (g = 0; g < `LANE_COUNT; g = g + 1) begin : lane
			lane_sync_monitor u_monitor (
				.mclk_in(mclk_in),
				.srst_in(srst_in),
				.lane_active_in(lane_active[g]),
				.char_valid_in(char_valid_in[g]),
				.comma_in(comma_in[g]),
				.sync_released_in(sync_request_n_ff),
				.align_done_in(align_done_in[g]),
				.cgs_pass_out(cgs_pass[g]),
				.align_pass_out(align_pass[g])
			);
		end
	endgenerate

	// Every enabled lane must have its comma run; disabled lanes do not hold the request.
	assign all_lanes_synced = (|lane_active) && ((cgs_pass | ~lane_active) == {`LANE_COUNT{1'b1}});

	always @(posedge mclk_in) begin
		if (srst_in) begin
			sync_request_n_ff <= 1'b0;
		end else begin
			sync_request_n_ff <= all_lanes_synced;
		end
	end

	// Read path. The answer is registered one edge after the read strobe and then held.
	always @* begin
		nxt_rdata = 8'h00;
		case (reg_addr_in)
			`OFS_TRANSPORT_TEST_CONTROL: begin
				nxt_rdata = transport_test_control_ff;
			end
			`OFS_EXPECTED_SAMPLE_LOW: begin
				nxt_rdata = expected_sample_low_ff;
			end
			`OFS_EXPECTED_SAMPLE_HIGH: begin
				nxt_rdata = expected_sample_high_ff;
			end
			`OFS_TRANSPORT_TEST_RESULT: begin
				nxt_rdata[`RESULT_FAIL_BIT] = transport_check_fail_flag_ff;
			end
			`OFS_COMMA_SYNC_LANE_STATUS: begin
				nxt_rdata = cgs_pass;
			end
			`OFS_LANE_ALIGN_SYNC_STATUS: begin
				nxt_rdata = align_pass;
			end
			`OFS_LINK_TEST_MODE: begin
				nxt_rdata = link_test_mode_ff;
			end
			default: begin
				nxt_rdata = 8'h00;
			end
		endcase
	end

	always @(posedge mclk_in) begin
		if (srst_in) begin
			rdata_ff <= 8'h00;
		end else if (reg_rd_in) begin
			rdata_ff <= nxt_rdata;
		end
	end

	assign reg_rdata_out = rdata_ff;
	assign sync_request_n_out = sync_request_n_ff;
	assign transport_check_fail_out = transport_check_fail_flag_ff;
	assign align_test_mode_out = link_test_mode_ff[`TEST_MODE_ALIGN_BIT];
	assign cgs_pass_out = cgs_pass;
	assign align_pass_out = align_pass;

endmodule
`default_nettype wire

/* File: test/link_test_assertions.sv */
// Port-level assertions for the receive link test logic.
`timescale 1ns/100ps
`default_nettype none
module link_test_checker (
	input wire mclk_in,
	input wire srst_in,
	input wire [11:0] reg_addr_in,
	input wire reg_wr_in,
	input wire reg_rd_in,
	input wire [7:0] reg_wdata_in,
	input wire [7:0] reg_rdata_out,
	input wire [3:0] lane_count_in,
	input wire link_enable_in,
	input wire frame_valid_in,
	input wire [7:0] char_valid_in,
	input wire [7:0] comma_in,
	input wire [7:0] align_done_in,
	input wire sync_request_n_out,
	input wire transport_check_fail_out,
	input wire align_test_mode_out,
	input wire [7:0] cgs_pass_out,
	input wire [7:0] align_pass_out
);
	logic [7:0] ctrl_ff;
	logic [2:0] run_ff;
	wire [8:0] act = (9'h1 << lane_count_in) - 9'h1;
	wire all_ok = (cgs_pass_out & act[7:0]) == act[7:0];
	wire arm = ctrl_ff[0] & ~ctrl_ff[1];
	wire odd = lane_count_in == 4'h3 || lane_count_in == 4'h6;
	wire fail = transport_check_fail_out;
	default clocking @(posedge mclk_in); endclocking
	default disable iff (srst_in);
	// The control bits and the comma run are not visible at the ports, so they are rebuilt here.
	always @(posedge mclk_in) begin
		if (srst_in)
			ctrl_ff <= 8'h00;
		else if (reg_wr_in && reg_addr_in == 12'h32c)
			ctrl_ff <= reg_wdata_in;
		if (srst_in || !link_enable_in || (char_valid_in[0] && !comma_in[0]))
			run_ff <= 3'h0;
		else if (char_valid_in[0] && run_ff != 3'h7)
			run_ff <= run_ff + 3'h1;
	end
	a_fail_sticky: assert property (fail && !ctrl_ff[1] |=> fail)
		else $error("fail flag lost");
	a_fail_clear: assert property (ctrl_ff[1] |=> !fail)
		else $error("fail flag not cleared");
	a_fail_cause: assert property ($rose(fail) |-> $past(frame_valid_in, 2) && $past(arm, 2))
		else $error("fail flag without armed frame");
	a_odd_lanes: assert property (frame_valid_in && arm && odd ##1 arm |=> fail)
		else $error("odd lane mode did not fail");
	a_result_read: assert property (reg_rd_in && reg_addr_in == 12'h32f |=> reg_rdata_out[0] == $past(fail))
		else $error("result read wrong");
	a_sync_wait: assert property ($rose(sync_request_n_out) |-> $past(all_ok))
		else $error("sync released early");
	a_cgs_four: assert property ($rose(cgs_pass_out[0]) |-> run_ff == 3'h4)
		else $error("comma pass not on fourth comma");
	a_align_pass: assert property ($rose(align_pass_out[0]) |-> $past(align_done_in[0]) && $past(sync_request_n_out))
		else $error("alignment pass without cause");
	a_mode_bit: assert property (reg_wr_in && reg_addr_in == 12'h477 |=> align_test_mode_out == $past(reg_wdata_in[7]))
		else $error("test mode bit wrong");
	cover property ($rose(fail));
	cover property ($rose(sync_request_n_out));
	cover property ($rose(align_pass_out[0]));
endmodule
bind serial_link_rx_transport_test link_test_checker chk_i (.*);
`default_nettype wire

/* File: test/link_tx_model.sv */
// Behavioural link transmitter sending test samples and sync characters.
`timescale 1ns/100ps
`default_nettype none
module link_tx_model #(
	parameter logic [15:0] BASE = 16'h1230
) (
	input wire mclk_in,
	input wire srst_in,
	input wire sync_request_n_out,
	input wire pat_en_in,
	input wire comma_en_in,
	input wire align_en_in,
	input wire slow_in,
	output logic frame_valid_in,
	output logic [63:0] conv0_samples_in,
	output logic [31:0] conv1_samples_in,
	output logic [7:0] char_valid_in,
	output logic [7:0] comma_in,
	output logic [7:0] align_done_in
);
	logic [3:0] cnt_ff;
	wire go = comma_en_in && !(slow_in && cnt_ff[0]);
	wire ilas = align_en_in && sync_request_n_out;
	always @(posedge mclk_in) begin
		cnt_ff <= srst_in ? 4'h0 : cnt_ff + 4'h1;
	end
	// Every sample differs; idle sample lines toggle so stale values are never mistaken for data.
	assign frame_valid_in = pat_en_in && !(slow_in && cnt_ff[0]);
	assign conv0_samples_in = pat_en_in ? {BASE + 16'h3, BASE + 16'h2, BASE + 16'h1, BASE} : {16{cnt_ff}};
	assign conv1_samples_in = pat_en_in ? {BASE + 16'h11, BASE + 16'h10} : {8{~cnt_ff}};
	assign char_valid_in = {8{go}};
	assign comma_in = go ? {8{!ilas}} : {8{cnt_ff[1]}};
	assign align_done_in = {8{go && ilas && cnt_ff[1:0] == 2'h2}};
endmodule
`default_nettype wire

/* File: test/tb_top.sv */
// Self-checking bench for the receive link test logic.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	localparam logic [15:0] BASE = 16'h1230;
	logic mclk_in = 1'b0;
	logic srst_in = 1'b1;
	logic [11:0] reg_addr_in = 12'h000;
	logic reg_wr_in = 1'b0;
	logic reg_rd_in = 1'b0;
	logic [7:0] reg_wdata_in = 8'h00;
	logic [3:0] lane_count_in = 4'h8;
	logic interp_bypass_in = 1'b0;
	logic link_enable_in = 1'b0;
	logic pat_en_in = 1'b0;
	logic comma_en_in = 1'b0;
	logic align_en_in = 1'b0;
	logic slow_in = 1'b0;
	wire [7:0] reg_rdata_out, char_valid_in, comma_in, align_done_in, cgs_pass_out, align_pass_out;
	wire frame_valid_in, sync_request_n_out, transport_check_fail_out, align_test_mode_out;
	wire [63:0] conv0_samples_in;
	wire [31:0] conv1_samples_in;
	int failures = 0;
	int cmp_count = 0;
	int cyc = 0;
	logic [7:0] d;
	logic [3:0] lt [8] = '{4'h8, 4'h8, 4'h4, 4'h2, 4'h1, 4'h3, 4'h6, 4'h6};
	logic bt [8] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
	serial_link_rx_transport_test uut (.*);
	link_tx_model #(.BASE(BASE)) tx (.*);
	initial begin
		forever #2.5 mclk_in = ~mclk_in;
	end
	always @(posedge mclk_in) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			failures++;
			$display("[ERR] timeout exp 0 got %0d", cyc);
			report_and_stop();
		end
	end
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			failures++;
			$display("[ERR] %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic wr_reg(input logic [11:0] a, input logic [7:0] v);
		@(posedge mclk_in);
		reg_addr_in <= a;
		reg_wdata_in <= v;
		reg_wr_in <= 1'b1;
		@(posedge mclk_in);
		reg_wr_in <= 1'b0;
	endtask
	task automatic rd_chk(input string n, input logic [11:0] a, input logic [7:0] e);
		@(posedge mclk_in);
		reg_addr_in <= a;
		reg_rd_in <= 1'b1;
		@(posedge mclk_in);
		reg_rd_in <= 1'b0;
		#1 chk(n, e, reg_rdata_out);
	endtask
	// Bypass swaps the middle samples; with eight lanes bit 0 picks the converter and bit 1 the sample, else bit 0 alone picks the converter.
	function automatic logic [15:0] exp_word(input logic b, input logic [3:0] l, input logic [3:0] s);
		logic [15:0] v;
		if (b)
			v = BASE + {14'h0, s[0], s[1]};
		else if (l == 4'h8)
			v = BASE + {11'h0, s[0], 3'h0, s[1]};
		else
			v = BASE + {11'h0, s[0], 4'h0};
		return v;
	endfunction
	task automatic run_check(input logic b, input logic [3:0] l, input logic [3:0] s, input logic bad);
		logic [15:0] e;
		e = exp_word(b, l, s) ^ (bad ? 16'h0001 << ($urandom % 16) : 16'h0000);
		@(posedge mclk_in);
		interp_bypass_in <= b;
		lane_count_in <= l;
		wr_reg(12'h32d, e[7:0]);
		wr_reg(12'h32e, e[15:8]);
		wr_reg(12'h32c, {s, 4'h3});
		repeat (1) @(posedge mclk_in);
		#1 chk("fail cleared", 8'h00, {7'h0, transport_check_fail_out});
		wr_reg(12'h32c, {s, 4'h1});
		repeat (8) @(posedge mclk_in);
		rd_chk("result", 12'h32f, {7'h0, bad || l == 4'h3 || l == 4'h6});
	endtask
	initial begin
		void'($urandom(47));
		repeat (4) @(posedge mclk_in);
		srst_in <= 1'b0;
		rd_chk("ctrl", 12'h32c, 8'h00);
		rd_chk("exp hi", 12'h32e, 8'h00);
		wr_reg(12'h32f, 8'hff);
		rd_chk("result ro", 12'h32f, 8'h00);
		wr_reg(12'h555, 8'h5a);
		rd_chk("unmapped", 12'h555, 8'h00);
		wr_reg(12'h32d, 8'ha5);
		rd_chk("exp lo", 12'h32d, 8'ha5);
		$display("test regs done");
		wr_reg(12'h477, 8'h80);
		rd_chk("mode", 12'h477, 8'h80);
		@(posedge mclk_in);
		slow_in <= 1'b1;
		link_enable_in <= 1'b1;
		comma_en_in <= 1'b1;
		align_en_in <= 1'b1;
		repeat (4) @(posedge mclk_in);
		#1 chk("sync held", 8'h00, {7'h0, sync_request_n_out});
		for (int i = 0; i < 60 && sync_request_n_out !== 1'b1; i++) @(posedge mclk_in);
		rd_chk("cgs pass", 12'h470, 8'hff);
		chk("sync out", 8'h01, {7'h0, sync_request_n_out});
		repeat (20) @(posedge mclk_in);
		rd_chk("align pass", 12'h473, 8'hff);
		@(posedge mclk_in);
		slow_in <= 1'b0;
		pat_en_in <= 1'b1;
		$display("test link done");
		for (int i = 0; i < 8; i++) begin
			for (int k = 0; k < 3; k++) begin
				run_check(bt[i], lt[i], k == 0 ? 4'hf : 4'($urandom % 16), k == 1 || (k == 2 && $urandom % 2 == 1));
			end
		end
		$display("test transport done");
		@(posedge mclk_in);
		srst_in <= 1'b1;
		repeat (2) @(posedge mclk_in);
		srst_in <= 1'b0;
		#1 chk("sync reset", 8'h00, {7'h0, sync_request_n_out});
		chk("fail reset", 8'h00, {7'h0, transport_check_fail_out});
		rd_chk("ctrl reset", 12'h32c, 8'h00);
		$display("test reset done");
		report_and_stop();
	end
endmodule
`default_nettype wire
